/* shared/ddcrg_pkg.sv */
// package: register map, reset values and codes for the tuner configuration bank
package ddcrg_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_OUT_CFG = 8'h06; // multiplex, pairing, format
	localparam logic [7:0] ADDR_TUNE_A = 8'h07; // tuning word a, lsb byte, four bytes
	localparam logic [7:0] ADDR_PHASE_A = 8'h0B; // phase word a, lsb byte, two bytes
	localparam logic [7:0] ADDR_TUNE_B = 8'h0D; // tuning word b, lsb byte
	localparam logic [7:0] ADDR_PHASE_B = 8'h11; // phase word b, lsb byte
	localparam logic [7:0] ADDR_SOURCE = 8'h13; // input crossbar
	localparam logic [7:0] ADDR_LOOP_CTRL = 8'h14; // exponent and gain loop control
	localparam logic [7:0] ADDR_LEGACY = 8'h15; // legacy count pair, two bytes
	localparam logic [7:0] ADDR_FIXED_A = 8'h17; // fixed gain channel a
	localparam logic [7:0] ADDR_FIXED_B = 8'h18; // fixed gain channel b
	localparam int REG_COUNT = 19; // bytes from 0x06 to 0x18
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_MULTIPLEX = 4;
	localparam int BIT_PAIRING = 5;
	localparam int BIT_FORMAT_LO = 6;
	localparam int BIT_SRC_A_LO = 0;
	localparam int BIT_SRC_B_LO = 2;
	localparam int BIT_EXP_FORCE = 0;
	localparam int BIT_LOOP_HOLD = 3;
	localparam int BIT_LOOP_SHIFT_LO = 4;
	// ------------------------------------------------------------
	// reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SOURCE = 8'h04; // second selector resets to 1
	localparam logic [7:0] RST_LOOP_CTRL = 8'h02; // legacy bit one resets to 1
	localparam logic [7:0] RST_OTHER = 8'h00;
	localparam logic [7:0] MASK_SOURCE = 8'h0F;
	localparam logic [7:0] MASK_LOOP_CTRL = 8'h3F;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	// ------------------------------------------------------------
	// codes and constants
	// ------------------------------------------------------------
	localparam logic [1:0] FMT_TRUNC8 = 2'h0;
	localparam logic [1:0] FMT_ROUND16 = 2'h1;
	localparam logic [1:0] FMT_ROUND24 = 2'h2;
	localparam logic [1:0] FMT_FLOAT = 2'h3;
	localparam logic [4:0] SER_LEN_TRUNC8 = 5'h08;
	localparam logic [4:0] SER_LEN_ROUND16 = 5'h10;
	localparam logic [4:0] SER_LEN_ROUND24 = 5'h18;
	localparam logic [4:0] SER_LEN_FLOAT = 5'h0C; // 8-bit mantissa plus 4-bit exponent
	localparam logic [1:0] SRC_FIRST = 2'h0;
	localparam logic [1:0] SRC_SECOND = 2'h1;
	localparam logic [2:0] EXP_MAX_GAIN = 3'h7;
	localparam logic [7:0] DATA_IDLE = 8'h00; // read data for unmapped addresses
endpackage

/* shared/ddcrg_cfg_if.sv */
// interface: output configuration handed from the register bank to the serial port
`timescale 1ns/1ps
interface ddcrg_cfg_if;
	logic multiplex; // both channels on the first pin
	logic pairing; // one frame sync per pair
	logic [1:0] format; // output number format code
	modport regs (output multiplex, output pairing, output format);
	modport port (input multiplex, input pairing, input format);
endinterface

/* rtl/ddcrg_serial_port.sv */
// module: output number formatting and serial framing for both channels
`timescale 1ns/1ps
module ddcrg_serial_port
	import ddcrg_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	ddcrg_cfg_if.port cfg,
	input wire logic sample_strobe_in,
	input wire logic [31:0] sample_i_first_in,
	input wire logic [31:0] sample_q_first_in,
	input wire logic [31:0] sample_i_second_in,
	input wire logic [31:0] sample_q_second_in,
	output logic [31:0] par_i_first_out,
	output logic [31:0] par_q_first_out,
	output logic [31:0] par_i_second_out,
	output logic [31:0] par_q_second_out,
	output logic serial_out_first_out,
	output logic serial_out_second_out,
	output logic serial_frame_sync_out,
	output logic serial_busy_out
);
	// ------------------------------------------------------------
	// formatting
	// ------------------------------------------------------------
	// rounding saturates so a near full-scale sample cannot wrap negative
	function automatic logic [31:0] fmt_word(input logic [31:0] w, input logic [1:0] f);
		logic [16:0] r16;
		logic [24:0] r24;
		logic [31:0] n;
		logic [3:0] e;
		r16 = {w[31], w[31:16]} + {16'h0000, w[15]};
		r24 = {w[31], w[31:8]} + {24'h000000, w[7]};
		n = w;
		e = 4'h0;
		for (int k = 0; k < 15; k++) begin
			if (n[31] == n[30]) begin
				n = {n[30:0], 1'b0};
				e = e + 4'h1;
			end
		end
		case (f)
			FMT_ROUND16: fmt_word = (r16[16] != r16[15]) ?
				{w[31], {15{~w[31]}}, 16'h0000} : {r16[15:0], 16'h0000};
			FMT_ROUND24: fmt_word = (r24[24] != r24[23]) ?
				{w[31], {23{~w[31]}}, 8'h00} : {r24[23:0], 8'h00};
			FMT_FLOAT: fmt_word = {n[31:24], e, 20'h00000};
			default: fmt_word = w; // serial keeps top 8, parallel all 32
		endcase
	endfunction

	// ------------------------------------------------------------
	// framing state
	// ------------------------------------------------------------
	typedef enum logic {DDCRG_IDLE, DDCRG_SHIFT} ddcrg_ser_state_t;
	ddcrg_ser_state_t state_reg; // sequencer state
	logic [4:0] bit_reg; // bit within current word
	logic [1:0] word_reg; // word within frame
	logic [4:0] len_reg; // serial word length latched at frame start
	logic mux_reg; // multiplex mode latched at frame start
	logic pair_reg; // pairing mode latched at frame start

	// ------------------------------------------------------------
	// word selection
	// ------------------------------------------------------------
	wire [4:0] len_now = (cfg.format == FMT_ROUND16) ? SER_LEN_ROUND16 :
		(cfg.format == FMT_ROUND24) ? SER_LEN_ROUND24 :
		(cfg.format == FMT_FLOAT) ? SER_LEN_FLOAT : SER_LEN_TRUNC8;
	// first pin walks i,q of a then i,q of b when multiplexed
	wire [31:0] word_first = mux_reg ?
		(word_reg == 2'h0 ? par_i_first_out : word_reg == 2'h1 ? par_q_first_out :
		word_reg == 2'h2 ? par_i_second_out : par_q_second_out) :
		(word_reg[0] ? par_q_first_out : par_i_first_out);
	wire [31:0] word_second = word_reg[0] ? par_q_second_out : par_i_second_out;
	wire [4:0] bit_pos = 5'h1F - bit_reg; // msb first
	wire last_bit = (bit_reg == len_reg - 5'h01);
	wire last_word = (word_reg == (mux_reg ? 2'h3 : 2'h1));
	wire start = (state_reg == DDCRG_IDLE) && sample_strobe_in;
	// in i-word position when word index even
	wire sync_now = (bit_reg == 5'h00) && (!pair_reg || !word_reg[0]);

	// ------------------------------------------------------------
	// sample capture: a strobe while shifting is ignored
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			par_i_first_out <= 32'h00000000;
			par_q_first_out <= 32'h00000000;
			par_i_second_out <= 32'h00000000;
			par_q_second_out <= 32'h00000000;
		end else if (start) begin
			par_i_first_out <= fmt_word(sample_i_first_in, cfg.format);
			par_q_first_out <= fmt_word(sample_q_first_in, cfg.format);
			par_i_second_out <= fmt_word(sample_i_second_in, cfg.format);
			par_q_second_out <= fmt_word(sample_q_second_in, cfg.format);
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= DDCRG_IDLE;
			bit_reg <= 5'h00;
			word_reg <= 2'h0;
			len_reg <= SER_LEN_TRUNC8;
			mux_reg <= 1'b0;
			pair_reg <= 1'b0;
		end else begin
			case (state_reg)
				DDCRG_IDLE: begin
					bit_reg <= 5'h00;
					word_reg <= 2'h0;
					if (start) begin
						state_reg <= DDCRG_SHIFT;
						len_reg <= len_now;
						mux_reg <= cfg.multiplex;
						pair_reg <= cfg.pairing;
					end
				end
				DDCRG_SHIFT: begin
					if (last_bit) begin
						bit_reg <= 5'h00;
						word_reg <= word_reg + 2'h1;
						if (last_word) begin
							state_reg <= DDCRG_IDLE;
						end
					end else begin
						bit_reg <= bit_reg + 5'h01;
					end
				end
				default: state_reg <= DDCRG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// sync coincides with first bit of each word, or only i word when paired
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			serial_out_first_out <= 1'b0;
			serial_out_second_out <= 1'b0;
			serial_frame_sync_out <= 1'b0;
			serial_busy_out <= 1'b0;
		end else if (state_reg == DDCRG_SHIFT) begin
			serial_out_first_out <= word_first[bit_pos];
			serial_out_second_out <= mux_reg ? 1'b0 : word_second[bit_pos];
			serial_frame_sync_out <= sync_now;
			serial_busy_out <= 1'b1;
		end else begin
			serial_out_first_out <= 1'b0;
			serial_out_second_out <= 1'b0;
			serial_frame_sync_out <= 1'b0;
			serial_busy_out <= 1'b0;
		end
	end
endmodule

/* rtl/ddcrg_config_regs.sv */
// module: configuration register bank of the two-channel tuner with gain control
`timescale 1ns/1ps
module ddcrg_config_regs
	import ddcrg_pkg::*;
#(
	parameter int SAMPLE_W = 14 // width of converter samples
)
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic chip_enable_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic [7:0] address_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n_out,
	input wire logic [SAMPLE_W-1:0] sample_in_first_in,
	input wire logic [SAMPLE_W-1:0] sample_in_second_in,
	input wire logic [SAMPLE_W-1:0] test_value_in,
	output logic [SAMPLE_W-1:0] channel_in_first_out,
	output logic [SAMPLE_W-1:0] channel_in_second_out,
	output logic [31:0] tuning_word_a_out,
	output logic [15:0] phase_word_a_out,
	output logic [31:0] tuning_word_b_out,
	output logic [15:0] phase_word_b_out,
	input wire logic [2:0] exponent_first_in,
	input wire logic [2:0] exponent_second_in,
	output logic [2:0] exponent_first_out,
	output logic [2:0] exponent_second_out,
	output logic gain_loop_hold_out,
	output logic [1:0] gain_loop_shift_out,
	output logic [7:0] fixed_gain_first_out,
	output logic [7:0] fixed_gain_second_out,
	input wire logic [7:0] loop_level_first_in,
	input wire logic [7:0] loop_level_second_in,
	output logic [2:0] external_gain_amplifier_first_out,
	output logic [2:0] external_gain_amplifier_second_out,
	input wire logic sample_strobe_in,
	input wire logic [31:0] sample_i_first_in,
	input wire logic [31:0] sample_q_first_in,
	input wire logic [31:0] sample_i_second_in,
	input wire logic [31:0] sample_q_second_in,
	output logic [31:0] par_i_first_out,
	output logic [31:0] par_q_first_out,
	output logic [31:0] par_i_second_out,
	output logic [31:0] par_q_second_out,
	output logic serial_out_first_out,
	output logic serial_out_second_out,
	output logic serial_frame_sync_out,
	output logic serial_busy_out
);
	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0] byte_reg [REG_COUNT]; // byte 0 sits at the output config offset
	logic [7:0] data_reg; // read data latch
	logic oe_n_reg; // data bus drive enable, low drives
	ddcrg_cfg_if cfg_bus (); // output configuration to the serial port

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire [7:0] rel_addr = address_in - ADDR_OUT_CFG; // index into byte store
	wire in_range = (address_in >= ADDR_OUT_CFG) && (address_in <= ADDR_FIXED_B);
	wire bus_write = !chip_enable_n_in && !write_n_in;
	wire bus_read = !chip_enable_n_in && !read_n_in;
	// reading outside the bank returns a fixed idle value
	wire [7:0] read_value = in_range ? byte_reg[rel_addr[4:0]] : DATA_IDLE;

	// ------------------------------------------------------------
	// byte registers, one per mapped address
	// ------------------------------------------------------------
	// reset and writable mask differ per byte, so each gets its own constant
	generate
		for (genvar g = 0; g < REG_COUNT; g++) begin : g_byte
			localparam logic [7:0] ADDR = ADDR_OUT_CFG + 8'(g);
			localparam logic [7:0] RST = (ADDR == ADDR_SOURCE) ? RST_SOURCE :
				(ADDR == ADDR_LOOP_CTRL) ? RST_LOOP_CTRL : RST_OTHER;
			localparam logic [7:0] MASK = (ADDR == ADDR_SOURCE) ? MASK_SOURCE :
				(ADDR == ADDR_LOOP_CTRL) ? MASK_LOOP_CTRL : MASK_FULL;
			wire hit = bus_write && (address_in == ADDR);
			// legacy bytes are stored like any other so they read back what the
			// host left in them; the device itself never looks at them
			always_ff @(posedge clock_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					byte_reg[g] <= RST;
				end else if (hit) begin
					byte_reg[g] <= data_in & MASK;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// data appears one clock after the read strobe is seen low
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			data_reg <= DATA_IDLE;
			oe_n_reg <= 1'b1;
		end else begin
			data_reg <= bus_read ? read_value : DATA_IDLE;
			oe_n_reg <= !bus_read;
		end
	end
	assign data_out = data_reg;
	assign data_oe_n_out = oe_n_reg;

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	localparam int I_CFG = ADDR_OUT_CFG - ADDR_OUT_CFG;
	localparam int I_TA = ADDR_TUNE_A - ADDR_OUT_CFG;
	localparam int I_PA = ADDR_PHASE_A - ADDR_OUT_CFG;
	localparam int I_TB = ADDR_TUNE_B - ADDR_OUT_CFG;
	localparam int I_PB = ADDR_PHASE_B - ADDR_OUT_CFG;
	localparam int I_SRC = ADDR_SOURCE - ADDR_OUT_CFG;
	localparam int I_LOOP = ADDR_LOOP_CTRL - ADDR_OUT_CFG;
	localparam int I_FA = ADDR_FIXED_A - ADDR_OUT_CFG;
	localparam int I_FB = ADDR_FIXED_B - ADDR_OUT_CFG;
	// low address carries the least significant byte
	assign tuning_word_a_out = {byte_reg[I_TA+3], byte_reg[I_TA+2],
		byte_reg[I_TA+1], byte_reg[I_TA]};
	assign tuning_word_b_out = {byte_reg[I_TB+3], byte_reg[I_TB+2],
		byte_reg[I_TB+1], byte_reg[I_TB]};
	assign phase_word_a_out = {byte_reg[I_PA+1], byte_reg[I_PA]};
	assign phase_word_b_out = {byte_reg[I_PB+1], byte_reg[I_PB]};
	wire [1:0] src_first = byte_reg[I_SRC][BIT_SRC_A_LO +: 2];
	wire [1:0] src_second = byte_reg[I_SRC][BIT_SRC_B_LO +: 2];
	wire exp_force = byte_reg[I_LOOP][BIT_EXP_FORCE];
	assign gain_loop_hold_out = byte_reg[I_LOOP][BIT_LOOP_HOLD];
	assign gain_loop_shift_out = byte_reg[I_LOOP][BIT_LOOP_SHIFT_LO +: 2];
	assign fixed_gain_first_out = byte_reg[I_FA];
	assign fixed_gain_second_out = byte_reg[I_FB];
	assign cfg_bus.multiplex = byte_reg[I_CFG][BIT_MULTIPLEX];
	assign cfg_bus.pairing = byte_reg[I_CFG][BIT_PAIRING];
	assign cfg_bus.format = byte_reg[I_CFG][BIT_FORMAT_LO +: 2];

	// ------------------------------------------------------------
	// per-channel crossbar, exponent and amplifier drive
	// ------------------------------------------------------------
	wire [1:0] src_sel [2];
	wire [2:0] exp_raw [2];
	wire [7:0] fixed_gain [2];
	wire [7:0] loop_level [2];
	logic [SAMPLE_W-1:0] chan_reg [2]; // routed converter input
	logic [2:0] exp_reg [2]; // exponent to the float-to-fixed stage
	logic [2:0] amp_reg [2]; // external amplifier gain code
	assign src_sel[0] = src_first;
	assign src_sel[1] = src_second;
	assign exp_raw[0] = exponent_first_in;
	assign exp_raw[1] = exponent_second_in;
	assign fixed_gain[0] = byte_reg[I_FA];
	assign fixed_gain[1] = byte_reg[I_FB];
	assign loop_level[0] = loop_level_first_in;
	assign loop_level[1] = loop_level_second_in;

	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			// codes 2 and 3 both pick the programmable test value
			wire [SAMPLE_W-1:0] routed = (src_sel[c] == SRC_FIRST) ? sample_in_first_in :
				(src_sel[c] == SRC_SECOND) ? sample_in_second_in : test_value_in;
			wire [2:0] exp_next = exp_force ? EXP_MAX_GAIN : exp_raw[c];
			// open loop: the programmed fixed gain owns the amplifier, closed loop:
			// the integrator's magnitude does; both inverted on the way out
			wire [7:0] gain_src = gain_loop_hold_out ? fixed_gain[c] : loop_level[c];
			wire [2:0] amp_next = ~gain_src[7:5];
			always_ff @(posedge clock_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					chan_reg[c] <= '0;
					exp_reg[c] <= 3'h0;
					amp_reg[c] <= 3'h7;
				end else begin
					chan_reg[c] <= routed;
					exp_reg[c] <= exp_next;
					amp_reg[c] <= amp_next;
				end
			end
		end
	endgenerate
	assign channel_in_first_out = chan_reg[0];
	assign channel_in_second_out = chan_reg[1];
	assign exponent_first_out = exp_reg[0];
	assign exponent_second_out = exp_reg[1];
	assign external_gain_amplifier_first_out = amp_reg[0];
	assign external_gain_amplifier_second_out = amp_reg[1];

	// ------------------------------------------------------------
	// serial and parallel output port
	// ------------------------------------------------------------
	ddcrg_serial_port u_serial (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.cfg(cfg_bus.port),
		.sample_strobe_in(sample_strobe_in),
		.sample_i_first_in(sample_i_first_in),
		.sample_q_first_in(sample_q_first_in),
		.sample_i_second_in(sample_i_second_in),
		.sample_q_second_in(sample_q_second_in),
		.par_i_first_out(par_i_first_out),
		.par_q_first_out(par_q_first_out),
		.par_i_second_out(par_i_second_out),
		.par_q_second_out(par_q_second_out),
		.serial_out_first_out(serial_out_first_out),
		.serial_out_second_out(serial_out_second_out),
		.serial_frame_sync_out(serial_frame_sync_out),
		.serial_busy_out(serial_busy_out)
	);
endmodule

/* sim/ddcrg_config_regs_props.sv */
// checker: port-level properties of the tuner configuration bank
`timescale 1ns/1ps
module ddcrg_config_regs_props
	import ddcrg_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic chip_enable_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic [7:0] address_in,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n_out,
	input wire logic [31:0] tuning_word_a_out,
	input wire logic [15:0] phase_word_b_out,
	input wire logic gain_loop_hold_out,
	input wire logic [7:0] fixed_gain_first_out,
	input wire logic [7:0] fixed_gain_second_out,
	input wire logic [7:0] loop_level_first_in,
	input wire logic [7:0] loop_level_second_in,
	input wire logic [2:0] external_gain_amplifier_first_out,
	input wire logic [2:0] external_gain_amplifier_second_out,
	input wire logic serial_frame_sync_out,
	input wire logic serial_busy_out
);
	// ----
	// helpers
	// ----
	// amplifier source: fixed gain while held, loop level otherwise
	wire [2:0] amp_src_a = gain_loop_hold_out ? fixed_gain_first_out[7:5] : loop_level_first_in[7:5];
	wire [2:0] amp_src_b = gain_loop_hold_out ? fixed_gain_second_out[7:5] : loop_level_second_in[7:5];
	wire rd_cyc = !chip_enable_n_in && !read_n_in; // read strobe with chip enable
	wire wr_cyc = !chip_enable_n_in && !write_n_in; // write strobe with chip enable
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);
	// ----
	// properties
	// ----
	read_drive_a: assert property (rd_cyc |=> !data_oe_n_out)
		else $error("bus not driven after read");
	bus_idle_a: assert property (!rd_cyc |=> data_oe_n_out && data_out == 8'h00)
		else $error("bus driven without read");
	unmapped_read_a: assert property (rd_cyc && (address_in < ADDR_OUT_CFG ||
		address_in > ADDR_FIXED_B) |=> data_out == 8'h00) else $error("unmapped read not zero");
	read_back_a: assert property (rd_cyc && write_n_in
		&& address_in == ADDR_FIXED_A |=> data_out == $past(fixed_gain_first_out))
		else $error("fixed gain readback");
	fixed_write_a: assert property (wr_cyc && address_in == ADDR_FIXED_A
		|=> fixed_gain_first_out == $past(data_in)) else $error("fixed gain write lost");
	tune_low_a: assert property (wr_cyc && address_in == ADDR_TUNE_A
		|=> tuning_word_a_out[7:0] == $past(data_in)) else $error("tuning lsb byte");
	phase_top_a: assert property (wr_cyc && address_in == ADDR_PHASE_B + 8'h01
		|=> phase_word_b_out[15:8] == $past(data_in)) else $error("phase msb byte");
	amp_first_a: assert property (1'b1
		|=> external_gain_amplifier_first_out == ~$past(amp_src_a))
		else $error("amplifier a gain");
	amp_second_a: assert property (1'b1
		|=> external_gain_amplifier_second_out == ~$past(amp_src_b))
		else $error("amplifier b gain");
	frame_start_a: assert property ($rose(serial_busy_out) |-> serial_frame_sync_out)
		else $error("frame without sync");
endmodule
bind ddcrg_config_regs ddcrg_config_regs_props u_props (.*);

/* sim/ddcrg_host_model.sv */
// partner: host processor on the 8-bit control bus
`timescale 1ns/1ps
module ddcrg_host_model (
	input wire logic clock_in,
	input wire logic [7:0] rd_data_in,
	input wire logic oe_n_in,
	output logic ce_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out
);
	// idle bus; released lines show inverted values, never stale ones
	initial begin
		ce_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// one byte write, held over exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#1;
		addr_out = a;
		wdata_out = d;
		ce_n_out = 1'b0;
		wr_n_out = 1'b0;
		@(posedge clock_in);
		#1;
		ce_n_out = 1'b1;
		wr_n_out = 1'b1;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	// one byte read: answer taken one edge after sampling
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
		@(posedge clock_in);
		#1;
		addr_out = a;
		ce_n_out = 1'b0;
		rd_n_out = 1'b0;
		@(posedge clock_in);
		@(posedge clock_in);
		#1;
		d = rd_data_in;
		oe = oe_n_in;
		ce_n_out = 1'b1;
		rd_n_out = 1'b1;
		addr_out = ~a;
	endtask
endmodule

/* sim/tb_ddcrg_config_regs.sv */
// testbench: configuration bank of the two-channel tuner
`timescale 1ns/1ps
module tb_ddcrg_config_regs
	import ddcrg_pkg::*;
;
	logic clock_in, reset_n_in, chip_enable_n_in, read_n_in, write_n_in, sample_strobe_in;
	logic [7:0] address_in, data_in, data_out, fixed_gain_first_out, fixed_gain_second_out;
	logic data_oe_n_out, gain_loop_hold_out, serial_out_first_out, serial_out_second_out;
	logic serial_frame_sync_out, serial_busy_out;
	logic [1:0] gain_loop_shift_out;
	logic [2:0] exponent_first_out, exponent_second_out;
	logic [2:0] external_gain_amplifier_first_out, external_gain_amplifier_second_out;
	logic [13:0] channel_in_first_out, channel_in_second_out;
	logic [31:0] tuning_word_a_out, tuning_word_b_out, par_i_first_out;
	logic [31:0] par_q_first_out, par_i_second_out, par_q_second_out;
	logic [15:0] phase_word_a_out, phase_word_b_out;
	logic [13:0] sample_in_first_in = 14'h0123, sample_in_second_in = 14'h2ABC;
	logic [13:0] test_value_in = 14'h1F0F;
	logic [2:0] exponent_first_in = 3'h2, exponent_second_in = 3'h5;
	logic [7:0] loop_level_first_in = 8'h5A, loop_level_second_in = 8'hC3;
	logic [31:0] sample_i_first_in = 32'h12345680, sample_q_first_in = 32'h0F0F0F0F;
	logic [31:0] sample_i_second_in = 32'h7ABCDEF0, sample_q_second_in = 32'h01020304;
	int err_count = 0;
	int total_checks = 0;
	ddcrg_config_regs dut (.*);
	ddcrg_host_model host (.clock_in(clock_in), .rd_data_in(data_out), .oe_n_in(data_oe_n_out),
		.ce_n_out(chip_enable_n_in), .rd_n_out(read_n_in), .wr_n_out(write_n_in),
		.addr_out(address_in), .wdata_out(data_in));
	// ----
	// common tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	function automatic logic [7:0] pv(input int a);
		return 8'(a * 29);
	endfunction
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic oe;
		host.rd(a, d, oe);
		chk({oe, d}, {1'b0, e});
	endtask
	// ----
	// scenarios
	// ----
	// reset values, unmapped neighbours included
	task automatic reset_vals;
		for (int a = 5; a < 8'h1A; a++) begin
			rdchk(8'(a), a == 8'h13 ? RST_SOURCE : a == 8'h14 ? RST_LOOP_CTRL : 8'h00);
		end
		rdchk(8'hFF, 8'h00);
		chk(external_gain_amplifier_first_out, {~loop_level_first_in[7:5]});
	endtask
	// every writable byte except loop control at 0x14; legacy places left alone
	task automatic regs_rw;
		for (int a = 6; a < 8'h19; a++) begin
			if (a < 8'h14 || a > 8'h16) host.wr(8'(a), pv(a));
		end
		for (int a = 6; a < 8'h19; a++) begin
			rdchk(8'(a), a == 8'h13 ? pv(a) & MASK_SOURCE : a == 8'h14 ? RST_LOOP_CTRL :
				(a == 8'h15 || a == 8'h16) ? 8'h00 : pv(a));
		end
		chk(tuning_word_a_out, {pv(10), pv(9), pv(8), pv(7)});
		chk(tuning_word_b_out, {pv(16), pv(15), pv(14), pv(13)});
		chk(phase_word_a_out, {pv(12), pv(11)});
		chk(phase_word_b_out, {pv(18), pv(17)});
		chk(fixed_gain_second_out, pv(24));
	endtask
	// all selector codes on both channels
	task automatic crossbar;
		logic [13:0] pick [4];
		pick = '{sample_in_first_in, sample_in_second_in, test_value_in, test_value_in};
		for (int c = 0; c < 4; c++) begin
			host.wr(ADDR_SOURCE, 8'({c[1:0], 2'(3 - c)}));
			@(posedge clock_in);
			#1;
			chk(channel_in_first_out, pick[3 - c]);
			chk(channel_in_second_out, pick[c]);
		end
	endtask
	// hold, shift, exponent force and amplifier gains
	task automatic loop_ctrl;
		logic [7:0] fa, fb;
		for (int s = 0; s < 4; s++) begin
			fa = 8'(s * 71);
			fb = 8'(224 - s * 67);
			host.wr(ADDR_FIXED_A, fa);
			host.wr(ADDR_FIXED_B, fb);
			host.wr(ADDR_LOOP_CTRL, 8'({s[1:0], s[0], 1'b0, 1'b1, s[1]}));
			@(posedge clock_in);
			#1;
			chk(gain_loop_shift_out, s);
			chk(gain_loop_hold_out, s[0]);
			chk(exponent_first_out, s[1] ? EXP_MAX_GAIN : exponent_first_in);
			chk(exponent_second_out, s[1] ? EXP_MAX_GAIN : exponent_second_in);
			chk(external_gain_amplifier_first_out,
				{~(s[0] ? fa[7:5] : loop_level_first_in[7:5])});
			chk(external_gain_amplifier_second_out,
				{~(s[0] ? fb[7:5] : loop_level_second_in[7:5])});
		end
	endtask
	// one frame: parallel value, frame length, sync count, first word bits
	task automatic serial(input logic [1:0] f, input logic m, input logic p, input logic [31:0] ep,
		input logic [31:0] es);
		int len, n, sy;
		logic [31:0] bits, bb;
		len = f == 0 ? 8 : f == 1 ? 16 : f == 2 ? 24 : 12;
		n = 0;
		sy = 0;
		bits = 32'h0;
		bb = 32'h0;
		host.wr(ADDR_OUT_CFG, {f, p, m, 4'h1});
		@(posedge clock_in);
		#1;
		sample_strobe_in = 1'b1;
		@(posedge clock_in);
		#1;
		sample_strobe_in = 1'b0;
		chk(par_i_first_out, ep);
		chk(par_i_second_out, es);
		if (f == FMT_TRUNC8) chk(par_q_first_out, sample_q_first_in);
		if (f == FMT_TRUNC8) chk(par_q_second_out, sample_q_second_in);
		for (int k = 0; k < 200 && !(n > 0 && !serial_busy_out); k++) begin
			@(posedge clock_in);
			#1;
			if (serial_busy_out) begin
				n++;
				sy += serial_frame_sync_out;
				if (n <= len) bits = {bits[30:0], serial_out_first_out};
				if (m) chk(serial_out_second_out, 1'b0);
				if (m ? n > 2 * len && n <= 3 * len : n <= len)
					bb = {bb[30:0], m ? serial_out_first_out : serial_out_second_out};
			end
		end
		if (n == 0 || serial_busy_out) begin
			err_count++;
			report_and_stop();
		end
		chk(n, m ? 4 * len : 2 * len);
		chk(sy, (m ? 2 : 1) * (p ? 1 : 2));
		chk(bits, ep >> (32 - len));
		chk(bb, es >> (32 - len));
	endtask
	// ----
	// clock and main sequence
	// ----
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	initial begin
		reset_n_in = 1'b0;
		sample_strobe_in = 1'b0;
		repeat (5) @(posedge clock_in);
		#1;
		reset_n_in = 1'b1;
		reset_vals();
		regs_rw();
		crossbar();
		loop_ctrl();
		serial(FMT_TRUNC8, 1'b0, 1'b0, 32'h12345680, 32'h7ABCDEF0);
		serial(FMT_ROUND16, 1'b1, 1'b0, 32'h12340000, 32'h7ABD0000);
		serial(FMT_ROUND24, 1'b0, 1'b1, 32'h12345700, 32'h7ABCDF00);
		serial(FMT_FLOAT, 1'b1, 1'b1, 32'h48200000, 32'h7A000000);
		report_and_stop();
	end
endmodule
